// *** rtl/result_queue_pkg.sv ***
// Shared constants for the spectral result queue
package result_queue_pkg;
  localparam logic [7:0] CFG_ADDR = 8'hd7;
  localparam logic [7:0] MAP_ADDR = 8'hfc;
  localparam logic [7:0] LVL_ADDR = 8'hfd;
  localparam logic [7:0] DLO_ADDR = 8'hfe;
  localparam logic [7:0] DHI_ADDR = 8'hff;
  localparam logic [6:0] CFG_RSV_RESET = 7'h21;
  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam int CFG_FLICKER_BIT = 7;
  localparam int MAP_STATUS_BIT = 0;
  localparam int MAP_CH5_BIT = 6;
  localparam int DEPTH = 128;
  localparam int CHANS = 6;
  localparam logic [7:0] LEVEL_MAX = 8'h80;
  // Slots of one sample: 0 status, 1..6 channels, 7 flicker
  localparam logic [2:0] SLOT_LAST = 3'h7;
  typedef enum logic [1:0] {ST_IDLE, ST_WALK} walk_e;
endpackage : result_queue_pkg

// *** rtl/skid_buffer.sv ***
// Two-entry valid/ready buffer between sample walker and queue storage
`timescale 1ns/10ps
module skid_buffer #(
  parameter int W = 16
) (
  input wire logic core_clk,          // Clock
  input wire logic rst,               // Async reset, high
  input wire logic in_valid,          // Word offered
  output logic in_ready,              // Room for a word
  input wire logic [W-1:0] in_data,   // Offered word
  output logic out_valid,             // Word held
  input wire logic out_ready,         // Drain accepts
  output logic [W-1:0] out_data       // Oldest word
);
  logic [W-1:0] mem_q [2];
  logic rd_q;
  logic wr_q;
  logic [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rd_q];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : skid_buffer

// *** rtl/spectral_result_fifo.sv ***
// Result queue: sample packing, 128-entry store, byte register access
// Behaviour
// - Map bits one to five push channels zero to four, two bytes each.
// - Map bit six pushes channel five, two bytes per sample.
// - With flicker detection on, map bit six is ignored.
// - Map bit zero pushes the status byte each sample.
// - Config bit seven pushes raw flicker samples, two bytes each.
// - Flicker bit ignored while flicker detection is off.
// - Config low bits reset to 0100001; host must not alter them.
// - Level register reports unread two-byte entries.
// - Storage is 256 bytes; level spans zero to 128.
// - Low data address gives bits 7:0, high address bits 15:8.
// - Map bits, flicker bit, level and data reset to zero.
// - An entry arriving when 128 are held sets overflow, is dropped.
// - Register pointer wraps from high data address to low one.
// - Read pointer and level advance once per entry, at high read.
// - Empty queue reads zero; interrupt asserted while data present.
`timescale 1ns/10ps
module spectral_result_fifo
  import result_queue_pkg::*;
(
  input wire logic core_clk,              // 100 MHz clock
  input wire logic rst,                   // Async reset, high
  input wire logic reg_wr,                // Register write strobe
  input wire logic reg_rd,                // Register read strobe
  input wire logic [7:0] reg_addr,        // Register address
  input wire logic [7:0] reg_wdata,       // Write data
  output logic [7:0] reg_rdata,           // Read data, held
  output logic [7:0] reg_addr_next,       // Pointer after this access
  input wire logic sample_valid,          // New sample ready, pulse
  output logic sample_ready,              // Walker idle, can take sample
  input wire logic [7:0] measure_status_byte, // Status byte
  input wire logic [CHANS*16-1:0] chan_data,  // Channels 0..5
  input wire logic [15:0] flicker_raw,    // Raw flicker word
  input wire logic flicker_detect_on,     // Flicker detection enabled
  output logic queue_overflow,            // Sticky overflow flag
  output logic queue_data_irq             // Data present
);
  logic [7:0] cfg_q;
  logic [7:0] map_q;
  logic [15:0] store_q [DEPTH];
  logic [6:0] wp_q;
  logic [6:0] rp_q;
  logic [7:0] lvl_q;
  logic [7:0] rdata_q;
  logic ovf_q;
  walk_e st_q;
  logic [2:0] slot_q;
  logic [7:0] st_byte_q;
  logic [CHANS*16-1:0] ch_q;
  logic [15:0] fl_q;
  logic [7:0] en_q;

  // Enable mask per slot, latched with the sample
  wire fd = flicker_detect_on;
  wire queue_take_status_byte = map_q[MAP_STATUS_BIT];
  wire [4:0] chan_takes = map_q[5:1];
  wire queue_take_chan_five = map_q[MAP_CH5_BIT] && !fd;
  wire queue_take_flicker_raw = cfg_q[CFG_FLICKER_BIT] && fd;
  wire [7:0] en_d = {queue_take_flicker_raw, queue_take_chan_five,
                     chan_takes, queue_take_status_byte};
  // A sample is captured only while the walker is idle
  wire take = sample_valid && sample_ready;
  assign sample_ready = (st_q == ST_IDLE);

  // Current slot word
  logic [15:0] slot_word;
  always_comb begin
    slot_word = fl_q;
    if (slot_q == 3'h0) slot_word = {8'h00, st_byte_q};
    else if (slot_q != SLOT_LAST)
      slot_word = ch_q[(slot_q - 3'h1)*16 +: 16];
  end

  logic sb_ready;
  logic sb_valid;
  logic [15:0] sb_data;
  // Disabled slots pass in one cycle; enabled ones wait for buffer room
  wire walk_valid = (st_q == ST_WALK) && en_q[slot_q];
  wire walk_step = (st_q == ST_WALK) && (!en_q[slot_q] || sb_ready);

  // The store never stalls the buffer; a full store drops the word instead
  skid_buffer #(.W(16)) u_buf (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(walk_valid),
    .in_ready(sb_ready),
    .in_data(slot_word),
    .out_valid(sb_valid),
    .out_ready(1'b1),
    .out_data(sb_data)
  );

  // Register access decode
  wire rd_hi = reg_rd && (reg_addr == DHI_ADDR);
  wire wr_cfg = reg_wr && (reg_addr == CFG_ADDR);
  wire wr_map = reg_wr && (reg_addr == MAP_ADDR);
  wire empty = (lvl_q == 8'h00);
  wire pop = rd_hi && !empty;
  // A word reaching a full store is dropped, not stalled, so a slow host
  // never holds up the measurement side
  wire full = (lvl_q == LEVEL_MAX);
  wire push = sb_valid && !full;
  wire [15:0] head = store_q[rp_q];
  wire [7:0] head_lo = empty ? 8'h00 : head[7:0];
  wire [7:0] head_hi = empty ? 8'h00 : head[15:8];

  // Block reads of the data port bounce between the two data addresses
  wire [7:0] addr_inc = reg_addr + 8'h01;
  assign reg_addr_next = (reg_addr == DHI_ADDR) ? DLO_ADDR
                                                : addr_inc;

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      CFG_ADDR: rd_mux = cfg_q;
      MAP_ADDR: rd_mux = map_q;
      LVL_ADDR: rd_mux = lvl_q;
      DLO_ADDR: rd_mux = head_lo;
      DHI_ADDR: rd_mux = head_hi;
      default: rd_mux = 8'h00;
    endcase
  end

  assign reg_rdata = rdata_q;
  assign queue_overflow = ovf_q;
  assign queue_data_irq = !empty;

  // Only the flicker bit of the config byte is writable; low bits stay put
  wire [7:0] cfg_d = wr_cfg ? {reg_wdata[CFG_FLICKER_BIT], cfg_q[6:0]}
                            : cfg_q;
  // Map bit seven is reserved and always reads zero
  wire [7:0] map_d = wr_map ? {1'b0, reg_wdata[6:0]} : map_q;
  // Read data is held until the next read strobe
  wire [7:0] rdata_d = reg_rd ? rd_mux : rdata_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= {1'b0, CFG_RSV_RESET};
      map_q <= MAP_RESET;
      rdata_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      map_q <= map_d;
      rdata_q <= rdata_d;
    end
  end

  // Pointers and level; 128 x 16 bits is 256 bytes
  wire [6:0] wp_d = push ? wp_q + 7'h01 : wp_q;
  wire [6:0] rp_d = pop ? rp_q + 7'h01 : rp_q;
  // Level counts entries held in the store, not those in the skid buffer
  wire [7:0] lvl_d = lvl_q + {7'h00, push} - {7'h00, pop};
  // Overflow is sticky: only reset clears it
  wire ovf_d = ovf_q || (sb_valid && full);

  // Entry storage carries no reset; empty reads are masked to zero
  always_ff @(posedge core_clk) begin
    if (push) store_q[wp_q] <= sb_data;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wp_q <= 7'h00;
      rp_q <= 7'h00;
      lvl_q <= 8'h00;
      ovf_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      lvl_q <= lvl_d;
      ovf_q <= ovf_d;
    end
  end

  // Sample walker: slots in fixed order, one slot per cycle
  walk_e st_d;
  logic [2:0] slot_d;
  wire walk_last = walk_step && (slot_q == SLOT_LAST);
  always_comb begin
    st_d = st_q;
    slot_d = slot_q;
    case (st_q)
      ST_IDLE: begin
        slot_d = 3'h0;
        if (take) st_d = ST_WALK;
      end
      ST_WALK: begin
        if (walk_step) slot_d = slot_q + 3'h1;
        if (walk_last) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      slot_q <= 3'h0;
    end else begin
      st_q <= st_d;
      slot_q <= slot_d;
    end
  end

  // Sample fields and slot enables are frozen for the whole walk
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_byte_q <= 8'h00;
      ch_q <= '0;
      fl_q <= 16'h0000;
      en_q <= 8'h00;
    end else if (take) begin
      st_byte_q <= measure_status_byte;
      ch_q <= chan_data;
      fl_q <= flicker_raw;
      en_q <= en_d;
    end
  end
endmodule : spectral_result_fifo

// *** tb/host_model.sv ***
// Host side of the register bus
`timescale 1ns/10ps
module host_model (
  input wire logic core_clk, // Clock
  input wire logic [7:0] reg_rdata, // Read data
  output logic reg_wr = 1'b0, // Write
  output logic reg_rd = 1'b0, // Read
  output logic [7:0] reg_addr = 8'h00, // Address
  output logic [7:0] reg_wdata = 8'h00 // Data
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    @(negedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : host_model

// *** tb/result_queue_asserts.sv ***
// Port checks for the result queue
`timescale 1ns/10ps
module result_queue_asserts
  import result_queue_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_rdata, // Data
  input wire logic [7:0] reg_addr_next, // Next
  input wire logic sample_valid, // Offer
  input wire logic sample_ready, // Idle
  input wire logic queue_overflow, // Overflow
  input wire logic queue_data_irq // Data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_wrap; reg_addr == DHI_ADDR |-> reg_addr_next == DLO_ADDR;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  property p_empty; reg_rd && reg_addr >= DLO_ADDR && !queue_data_irq
    |=> reg_rdata == 8'h00; endproperty
  a_empty: assert property (p_empty) else $error("empty data");
  property p_lvl; reg_rd && reg_addr == LVL_ADDR
    |=> (reg_rdata != 8'h00) == $past(queue_data_irq); endproperty
  a_lvl: assert property (p_lvl) else $error("level irq");
  property p_cap; reg_rd && reg_addr == LVL_ADDR |=> reg_rdata <= LEVEL_MAX;
  endproperty
  a_cap: assert property (p_cap) else $error("level max");
  property p_busy; sample_valid && sample_ready |=> !sample_ready [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("walk short");
  property p_ovf; queue_overflow |=> queue_overflow; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow lost");
  property p_ovfirq; $rose(queue_overflow) |-> queue_data_irq; endproperty
  a_ovfirq: assert property (p_ovfirq) else $error("ovf irq");
  property p_cfg; reg_rd && reg_addr == CFG_ADDR
    |=> reg_rdata[6:0] == CFG_RSV_RESET; endproperty
  a_cfg: assert property (p_cfg) else $error("cfg low");
endmodule : result_queue_asserts

// *** tb/tb.sv ***
// Self-checking bench for the result queue
`timescale 1ns/10ps
module tb;
  import result_queue_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sample_valid = 1'b0;
  logic flicker_detect_on = 1'b0;
  logic [7:0] sb = 8'h5a;
  logic [95:0] cd = 96'hf5f5_e4e4_d3d3_c2c2_b1b1_a0a0;
  logic [15:0] fr = 16'h9c3e;
  logic reg_wr, reg_rd, sample_ready, queue_overflow, queue_data_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, reg_addr_next;
  int failures = 0;
  int n_checks = 0;
  always #5 core_clk = ~core_clk;
  host_model h (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  spectral_result_fifo uut (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_addr_next(reg_addr_next),
    .sample_valid(sample_valid),
    .sample_ready(sample_ready), .measure_status_byte(sb), .chan_data(cd),
    .flicker_raw(fr), .flicker_detect_on(flicker_detect_on),
    .queue_overflow(queue_overflow), .queue_data_irq(queue_data_irq));
  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    h.rd(a, d);
    check({8'h00, d}, {8'h00, exp});
  endtask : rchk
  task automatic push;
    for (int k = 0; k < 40 && sample_ready !== 1'b1; k++) @(negedge core_clk);
    if (sample_ready !== 1'b1) begin
      failures++;
      close_out();
    end
    sample_valid = 1'b1;
    @(negedge core_clk);
    sample_valid = 1'b0;
    repeat (12) @(negedge core_clk);
  endtask : push
  task automatic t_reset;
    rchk(CFG_ADDR, 8'h21);
    rchk(MAP_ADDR, 8'h00);
    rchk(LVL_ADDR, 8'h00);
    rchk(DHI_ADDR, 8'h00);
    $display("done reset values");
  endtask : t_reset
  task automatic t_order(input logic fd);
    logic [15:0] e[$];
    flicker_detect_on = fd;
    h.wr(MAP_ADDR, 8'h7f);
    rchk(MAP_ADDR, 8'h7f);
    h.wr(CFG_ADDR, 8'ha1);
    push();
    check({15'h0, queue_data_irq}, 16'h0001);
    e.push_back({8'h00, sb});
    for (int i = 0; i < 5; i++) e.push_back(cd[i*16 +: 16]);
    if (!fd) e.push_back(cd[95:80]);
    if (fd) e.push_back(fr);
    rchk(LVL_ADDR, 8'h07);
    foreach (e[i]) begin
      rchk(DLO_ADDR, e[i][7:0]);
      rchk(DHI_ADDR, e[i][15:8]);
      check({8'h00, reg_addr_next}, {8'h00, DLO_ADDR});
    end
    rchk(LVL_ADDR, 8'h00);
    rchk(DHI_ADDR, 8'h00);
    $display("done order flicker=%0d", fd);
  endtask : t_order
  task automatic t_full;
    h.wr(MAP_ADDR, 8'h02);
    repeat (129) push();
    rchk(LVL_ADDR, 8'h80);
    check({15'h0, queue_overflow}, 16'h0001);
    rchk(DLO_ADDR, cd[7:0]);
    $display("done overflow");
  endtask : t_full
  initial begin
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    t_reset();
    t_order(1'b1);
    t_order(1'b0);
    t_full();
    close_out();
  end
endmodule : tb
bind spectral_result_fifo result_queue_asserts u_chk (.core_clk(core_clk),
  .rst(rst), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .reg_addr_next(reg_addr_next), .sample_valid(sample_valid),
  .sample_ready(sample_ready), .queue_overflow(queue_overflow),
  .queue_data_irq(queue_data_irq));
